// >>> pkg/pbs_pkg.sv
// How it works
// - advance_load_n low ends any burst and loads new address and control.
// - with advance_load_n high the read/write input is ignored.
// - burst direction is the read/write level captured on the load cycle.
// - only the two low address bits advance, four words per burst.
// - read/write low on a load starts a write, high starts a read.
// - clk_gate_n high keeps the edge from moving the burst state and the pipeline.
// - on a gated edge every register keeps its value except the oe sample and the bus output registers.
// - selected only when both low enables are low and select_high is high.
// - data outputs are high impedance from the first reset edge until a read with oe low drives them.
// - read data appears one enabled cycle plus one edge, gated or not, after its address is taken.
package pbs_pkg;
  localparam int ADDR_W     = 17;
  localparam int BYTES      = 4;
  localparam int BYTE_W     = 9;
  localparam int DATA_W     = BYTES * BYTE_W;
  localparam int PIPE_DEPTH = 2;
  localparam int BURST_W    = 2;

  // one pipeline slot: a pending access
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [BYTES-1:0]  byte_wr_n;
  } pbs_slot_s;
endpackage

// >>> rtl/pbs_burst_ctr.sv
`timescale 1ns/1ps
module pbs_burst_ctr
  import pbs_pkg::*;
#(
  parameter int W = pbs_pkg::BURST_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic         en_i,
  input  wire logic         load_i,
  input  wire logic         linear_i,
  input  wire logic [W-1:0] base_i,
  output logic      [W-1:0] low_o
);
  logic [W-1:0] base_r;
  logic         lin_r;
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_r  <= '0;
      base_r <= '0;
      lin_r  <= 1'b0;
    end else if (en_i) begin
      if (load_i) begin
        // first continuation must already be one step past the base
        cnt_r  <= W'(1);
        base_r <= base_i;
        lin_r  <= linear_i;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  always_comb begin
    if (lin_r) low_o = base_r + cnt_r;
    else       low_o = base_r ^ cnt_r;
  end
endmodule // pbs_burst_ctr

// >>> rtl/pbs_port.sv
`timescale 1ns/1ps
module pbs_port
  import pbs_pkg::*;
#(
  parameter int AW = pbs_pkg::ADDR_W,
  parameter int NB = pbs_pkg::BYTES,
  parameter int BW = pbs_pkg::BYTE_W
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             clk_gate_n_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic             rd_wr_n_i,
  input  wire logic             advance_load_n_i,
  input  wire logic             select_low_a_n_i,
  input  wire logic             select_low_b_n_i,
  input  wire logic             select_high_i,
  input  wire logic             out_en_n_i,
  input  wire logic             burst_order_sel_n_i,
  input  wire logic [NB-1:0]    byte_write_n_i,
  input  wire logic [NB*BW-1:0] dq_i,
  output logic      [NB*BW-1:0] dq_o,
  output logic                  dq_oe_n_o
);
  import pbs_pkg::*;

  localparam int DW = NB * BW;
  localparam int DEPTH = 1 << AW;

  logic [DW-1:0]   mem [DEPTH];
  logic            en;
  logic            sel;
  logic            busy_r;
  logic            dir_wr_r;
  logic [AW-1:0]   base_r;
  logic [1:0]      low;
  pbs_slot_s       cur;
  pbs_slot_s       s1_r;
  pbs_slot_s       s2_r;
  logic            drive_r;
  logic            oe_seen_n_r;
  logic [DW-1:0]   rdata_r;
  logic [DW-1:0]   rd_word;

  assign en = ~clk_gate_n_i;
  assign sel = ~select_low_a_n_i & ~select_low_b_n_i & select_high_i;

  // load on advance_load_n low; keep direction
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      busy_r   <= 1'b0;
      dir_wr_r <= 1'b0;
      base_r   <= '0;
    end else if (en && !advance_load_n_i) begin
      busy_r   <= sel;
      dir_wr_r <= ~rd_wr_n_i;
      base_r   <= addr_i;
    end
  end

  pbs_burst_ctr #(.W(2)) u_ctr (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .en_i      (en),
    .load_i    (~advance_load_n_i),
    .linear_i  (~burst_order_sel_n_i),
    .base_i    (addr_i[1:0]),
    .low_o     (low)
  );

  // current access; read/write ignored while continuing
  always_comb begin
    cur = '0;
    if (!advance_load_n_i) begin
      cur.valid = sel;
      cur.write = ~rd_wr_n_i;
      cur.addr  = addr_i;
    end else begin
      cur.valid = busy_r;
      cur.write = dir_wr_r;
      cur.addr  = {base_r[AW-1:2], low};
    end
    cur.byte_wr_n = byte_write_n_i;
  end

  // two stage pipeline; enables lead data by two
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (en) begin
      s1_r <= cur;
      s2_r <= s1_r;
    end
  end

  // write data lands with the slot two stages down
  always_ff @(posedge clk_sys_i) begin
    if (en && s2_r.valid && s2_r.write) begin
      for (int b = 0; b < NB; b++) begin
        if (!s2_r.byte_wr_n[b])
          mem[s2_r.addr][b*BW +: BW] <= dq_i[b*BW +: BW];
      end
    end
  end

  // read word with bypass of the write landing on the same edge
  // without it a read right behind a write would return stale data
  always_comb begin
    rd_word = mem[s1_r.addr];
    if (s2_r.valid && s2_r.write && s2_r.addr == s1_r.addr) begin
      for (int b = 0; b < NB; b++) begin
        if (!s2_r.byte_wr_n[b])
          rd_word[b*BW +: BW] = dq_i[b*BW +: BW];
      end
    end
  end

  // read data and drive flag for the bus
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_r <= '0;
      drive_r <= 1'b0;
    end else if (en) begin
      drive_r <= s1_r.valid & ~s1_r.write;
      if (s1_r.valid && !s1_r.write)
        rdata_r <= rd_word;
    end
  end

  // oe is asynchronous on a real part; here it is sampled each cycle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) oe_seen_n_r <= 1'b1;
    else        oe_seen_n_r <= out_en_n_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      dq_o      <= '0;
      dq_oe_n_o <= 1'b1;
    end else begin
      dq_o      <= rdata_r;
      dq_oe_n_o <= ~(drive_r & ~oe_seen_n_r);
    end
  end

  property p_gate_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      clk_gate_n_i |=> (s1_r == $past(s1_r) && s2_r == $past(s2_r));
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("pipeline moved on gated edge");

  property p_state_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      clk_gate_n_i |=> (base_r == $past(base_r) && busy_r == $past(busy_r));
  endproperty
  a_state_hold: assert property (p_state_hold)
    else $error("burst state moved on gated edge");

  property p_load;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!clk_gate_n_i && !advance_load_n_i) |=> base_r == $past(addr_i);
  endproperty
  a_load: assert property (p_load)
    else $error("address not loaded");

  property p_dir;
    @(posedge clk_sys_i) disable iff (srst_i)
      advance_load_n_i |=> dir_wr_r == $past(dir_wr_r);
  endproperty
  a_dir: assert property (p_dir)
    else $error("burst direction changed");

  property p_write_start;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!clk_gate_n_i && !advance_load_n_i && sel && !rd_wr_n_i)
        |=> (s1_r.valid && s1_r.write);
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("write not started");

  property p_desel;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!clk_gate_n_i && !advance_load_n_i && !sel) |=> !s1_r.valid;
  endproperty
  a_desel: assert property (p_desel)
    else $error("access issued while deselected");

  property p_upper;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!clk_gate_n_i && busy_r) ##1 advance_load_n_i
        |-> cur.addr[AW-1:2] == $past(cur.addr[AW-1:2]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper address changed in burst");

  // first step of a burst follows the chosen order
  property p_wrap;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!clk_gate_n_i && !advance_load_n_i) ##1 advance_load_n_i
        |-> cur.addr[1:0] == ($past(burst_order_sel_n_i)
                              ? $past(addr_i[1:0]) ^ 2'b01
                              : $past(addr_i[1:0]) + 2'b01);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst order step wrong");

  // write load floats bus two cycles later
  property p_float;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!clk_gate_n_i && !advance_load_n_i && !rd_wr_n_i)
        ##1 !clk_gate_n_i |=> ##1 dq_oe_n_o;
  endproperty
  a_float: assert property (p_float)
    else $error("bus driven after write load");
endmodule // pbs_port

// >>> sim/pbs_ctl_model.sv
`timescale 1ns/1ps
// controller side of the port: supplies write data late
module pbs_ctl_model
  import pbs_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      gate_n_i,
  input  wire logic [pbs_pkg::DATA_W-1:0] wd_i,
  output logic      [pbs_pkg::DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] d1_r = '0;

  // data trails enables
  // enables go out with the address, data two enabled edges later
  always_ff @(posedge clk_sys_i) begin
    if (!gate_n_i) begin
      d1_r <= wd_i;
      dq_o <= d1_r;
    end
  end
endmodule // pbs_ctl_model

// >>> sim/pipelined_burst_sram_port_tb.sv
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb;
  import pbs_pkg::*;
  `define CHK(n, e, s) begin total_checks++; \
    if ((e) !== (s)) begin num_errors++; \
    $display("wrong value %s exp %h seen %h", n, e, s); end end
  logic              clk_sys_i    = 0;
  logic              srst_i       = 1;
  logic              gate_n       = 0;
  logic              rw           = 1;
  logic              adv_n        = 1;
  logic [2:0]        sel          = 3'b110; // low_a_n, low_b_n, high
  logic              burst_order_sel_n          = 0;
  logic [ADDR_W-1:0] addr         = '0;
  logic [BYTES-1:0]  bw_n         = '1;
  logic              oe_n         = 0;
  logic [DATA_W-1:0] ev;
  logic [DATA_W-1:0] wd           = '0;
  logic [DATA_W-1:0] dq_i;
  logic [DATA_W-1:0] dq_o;
  logic              dq_oe_n;
  logic [DATA_W-1:0] mem [32];
  logic [DATA_W-1:0] exq [$];
  logic [31:0]       lf           = 32'hcff19202;
  logic [31:0]       r;
  logic [2:0]        s;
  logic [1:0]        gh           = 2'b11;
  int                num_errors   = 0;
  int                total_checks = 0;

  // free-running bench clock
  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  pbs_port i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .clk_gate_n_i(gate_n), .addr_i(addr), .rd_wr_n_i(rw),
    .advance_load_n_i(adv_n), .select_low_a_n_i(sel[2]),
    .select_low_b_n_i(sel[1]), .select_high_i(sel[0]), .out_en_n_i(oe_n),
    .burst_order_sel_n_i(burst_order_sel_n), .byte_write_n_i(bw_n), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n));
  pbs_ctl_model i_ctl (.clk_sys_i(clk_sys_i), .gate_n_i(gate_n),
    .wd_i(wd), .dq_o(dq_i));

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one enabled cycle, preceded by random ignored edges
  task automatic step(logic ld, logic wr, logic [4:0] a,
                      logic [DATA_W-1:0] d, logic [BYTES-1:0] be,
                      logic [2:0] sv);
    while (rnd() % 5 == 0) begin
      gate_n <= 1;
      adv_n  <= lf[3];
      rw     <= lf[4];
      addr   <= lf[ADDR_W+4:5];
      @(posedge clk_sys_i);
    end
    r = rnd();
    gate_n <= 0;
    adv_n  <= !ld;
    rw     <= ld ? !wr : r[0];
    addr   <= ld ? ADDR_W'(a) : r[ADDR_W:1];
    sel    <= sv;
    bw_n   <= be;
    wd     <= d;
    @(posedge clk_sys_i);
  endtask

  // one burst; expectations noted in issue order
  task automatic op(logic wr, logic [4:0] b, int len, logic il,
                    logic [2:0] sv, logic [BYTES-1:0] be);
    logic [4:0]        a;
    logic [DATA_W-1:0] d;
    burst_order_sel_n <= il;
    for (int k = 0; k < len; k++) begin
      a = {b[4:2], il ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
      d = {rnd(), lf[7:4]};
      if (sv == 3'b001 && wr) begin
        for (int i = 0; i < BYTES; i++)
          if (!be[i]) mem[a][i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
      end else if (sv == 3'b001)
        exq.push_back(mem[a]);
      step(k == 0, wr, a, d, be, sv);
    end
  endtask

  // result watch: new word only after an enabled edge
  always @(negedge clk_sys_i) begin
    if (gh[1] == 1'b0 && dq_oe_n === 1'b0) begin
      if (exq.size() == 0)
        `CHK("surplus drive", 1'b1, dq_oe_n)
      else begin
        // pop once: the macro names its expected value twice
        ev = exq.pop_front();
        `CHK("dq_o", ev, dq_o)
      end
    end
    gh = {gh[0], gate_n};
  end

  // main sequence: fill, then random mix
  initial begin
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 0;
    #1 `CHK("oe after reset", 1'b1, dq_oe_n)
    @(posedge clk_sys_i);
    for (int g = 0; g < 8; g++) op(1'b1, 5'(g * 4), 4, 1'b0, 3'b001, 4'h0);
    repeat (200) begin
      r = rnd();
      s = r[9:8] != 2'b00 ? 3'b001 : (r[12:10] == 3'b001 ? 3'b000 : r[12:10]);
      op(r[0], r[5:1], s == 3'b001 ? int'(r[14:13]) + 1 : 1, r[6], s,
         r[19:16]);
    end
    repeat (4) op(1'b0, 5'h0, 1, 1'b0, 3'b000, 4'hf);
    `CHK("pending reads", 0, exq.size())
    // oe high: a selected read must leave the bus floating
    oe_n <= 1'b1;
    step(1'b1, 1'b0, 5'h5, '0, 4'hf, 3'b001);
    repeat (4) op(1'b0, 5'h0, 1, 1'b0, 3'b000, 4'hf);
    oe_n <= 1'b0;
    give_verdict();
  end

  // hang guard, well past the expected run length
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule // pipelined_burst_sram_port_tb
